// file: srp_pkg.sv
package srp_pkg;
	// Configuration widths
	localparam int DATA_W_X8 = 8;
	localparam int DATA_W_X36 = 36;
	localparam int ADDR_W_X8 = 21;
	localparam int ADDR_W_X9 = 21;
	localparam int ADDR_W_X18 = 20;
	localparam int ADDR_W_X36 = 19;
	localparam int NIBBLE_W = 4;
	localparam int LANE_W = 9;
	localparam int BURST_LEN = 4;
	localparam int SUB_ARRAYS = 4;
	localparam int FIFO_DEPTH = 8;
	// Default model burst-location address width in bits, 64 locations (full part is large)
	localparam int MODEL_LOC_W = 6;
	localparam logic [1:0] BEAT_FIRST = 2'h0;
	localparam logic [1:0] BEAT_LAST = 2'h3;
	localparam logic [3:0] MASK_NONE = 4'hf;

	typedef enum logic [1:0] {
		SRP_IDLE = 2'b00,
		SRP_BURST = 2'b01
	} srp_state_t;

	// Mask expansion: one mask bit per lane, nibble lanes when narrow
	function automatic logic [35:0] srp_lane_keep(input logic [3:0] mask_n, input int dw);
		logic [35:0] keep;
		keep = '0;
		if (dw == 8) begin
			keep[3:0] = {4{~mask_n[0]}};
			keep[7:4] = {4{~mask_n[1]}};
		end else begin
			keep[8:0] = {9{~mask_n[0]}};
			keep[17:9] = {9{~mask_n[1]}};
			keep[26:18] = {9{~mask_n[2]}};
			keep[35:27] = {9{~mask_n[3]}};
		end
		return keep;
	endfunction
endpackage

// file: srp_fifo.sv
`timescale 1ns/10ps
module srp_fifo import srp_pkg::*; #(
	parameter int WIDTH = 8,
	parameter int DEPTH = FIFO_DEPTH
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [WIDTH-1:0] in_data_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	output logic [WIDTH-1:0] out_data_out,
	output logic out_valid_out,
	input wire logic out_ready_in
);
	localparam int PW = $clog2(DEPTH);
	typedef struct packed {
		logic [PW-1:0] wr;
		logic [PW-1:0] rd;
		logic [PW:0] count;
	} srp_fifo_st_t;
	srp_fifo_st_t st, next_st;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push;
	logic pop;

	assign in_ready_out = (st.count < (PW+1)'(DEPTH));
	assign out_valid_out = (st.count != '0);
	assign push = in_valid_in && in_ready_out;
	assign pop = out_valid_out && out_ready_in;
	assign out_data_out = mem[st.rd];

	always_comb begin
		next_st = st;
		if (push) begin
			next_st.wr = st.wr + PW'(1);
		end
		if (pop) begin
			next_st.rd = st.rd + PW'(1);
		end
		next_st.count = st.count + (PW+1)'(push) - (PW+1)'(pop);
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	always_ff @(posedge clk_in) begin
		if (push) begin
			mem[st.wr] <= in_data_in;
		end
	end
endmodule

// file: srp_mem.sv
`timescale 1ns/10ps
module srp_mem import srp_pkg::*; #(
	parameter int WIDTH = 36,
	parameter int AW = 8
) (
	input wire logic clk_in,
	input wire logic wr_en_in,
	input wire logic [AW-1:0] wr_addr_in,
	input wire logic [WIDTH-1:0] wr_data_in,
	input wire logic [WIDTH-1:0] wr_keep_in,
	input wire logic [AW-1:0] rd_addr_in,
	output logic [WIDTH-1:0] rd_data_out
);
	logic [WIDTH-1:0] mem [2**AW];

	// Kept lanes update, others retain old contents
	always_ff @(posedge clk_in) begin
		if (wr_en_in) begin
			mem[wr_addr_in] <= (mem[wr_addr_in] & ~wr_keep_in) | (wr_data_in & wr_keep_in);
		end
		rd_data_out <= mem[rd_addr_in];
	end
endmodule

// file: srp_sram.sv
`timescale 1ns/10ps
module srp_sram import srp_pkg::*; #(
	parameter int DATA_W = DATA_W_X36,
	parameter int ADDR_W = ADDR_W_X36,
	parameter int LOC_W = MODEL_LOC_W,
	parameter int FIFO_D = FIFO_DEPTH
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic k_rise_in,
	input wire logic kn_rise_in,
	input wire logic c_rise_in,
	input wire logic cn_rise_in,
	input wire logic single_clock_in,
	input wire logic wr_port_sel_n_in,
	input wire logic rd_port_sel_n_in,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [DATA_W-1:0] wr_data_in,
	input wire logic [3:0] byte_wr_mask_n_in,
	input wire logic [1:0] nibble_wr_mask_n_in,
	output logic [DATA_W-1:0] rd_data_out,
	output logic rd_data_oe_out,
	output logic wr_ready_out
);
	// ====================================================
	// Sizes
	// ====================================================
	// address width
	localparam int CFG_AW = (DATA_W <= 9) ? ADDR_W_X8 : (DATA_W <= 18) ? ADDR_W_X18 : ADDR_W_X36;
	localparam int SUB_W = $clog2(SUB_ARRAYS);
	localparam int MEM_AW = LOC_W + 2;
	localparam int ENTRY_W = DATA_W + DATA_W + MEM_AW;

	typedef struct packed {
		srp_state_t wr_state;
		logic [1:0] wr_beat;
		logic [LOC_W-1:0] wr_loc;
		srp_state_t rd_state;
		logic [1:0] rd_beat;
		logic [LOC_W-1:0] rd_loc;
		logic rd_active;
		logic oe;
		logic [DATA_W-1:0] q;
	} srp_st_t;

	srp_st_t st, next_st;
	logic [3:0] mask_n;
	logic [DATA_W-1:0] keep;
	logic cap_edge;
	logic out_edge;
	logic fifo_in_valid;
	logic [ENTRY_W-1:0] fifo_in;
	logic [ENTRY_W-1:0] fifo_out;
	logic fifo_out_valid;
	logic [DATA_W-1:0] mem_q;
	logic [MEM_AW-1:0] rd_addr;

	// ====================================================
	// Write capture
	// ====================================================
	// nibble masks on narrow part
	assign mask_n = (DATA_W == DATA_W_X8) ? {2'h3, nibble_wr_mask_n_in} : byte_wr_mask_n_in;
	assign keep = DATA_W'(srp_lane_keep(mask_n, DATA_W));
	assign cap_edge = k_rise_in || kn_rise_in;
	assign fifo_in = {wr_data_in, keep, MEM_AW'({st.wr_loc, st.wr_beat})};
	assign fifo_in_valid = (st.wr_state == SRP_BURST) && cap_edge;

	// Lane-level merge (byte lanes, nibble lanes when narrow) done in the array
	srp_fifo #(
		.WIDTH(ENTRY_W),
		.DEPTH(FIFO_D)
	) u_fifo (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.in_data_in(fifo_in),
		.in_valid_in(fifo_in_valid),
		.in_ready_out(wr_ready_out),
		.out_data_out(fifo_out),
		.out_valid_out(fifo_out_valid),
		.out_ready_in(1'b1)
	);

	srp_mem #(
		.WIDTH(DATA_W),
		.AW(MEM_AW)
	) u_mem (
		.clk_in(clk_in),
		.wr_en_in(fifo_out_valid),
		.wr_addr_in(fifo_out[MEM_AW-1:0]),
		.wr_data_in(fifo_out[ENTRY_W-1 -: DATA_W]),
		.wr_keep_in(fifo_out[MEM_AW +: DATA_W]),
		.rd_addr_in(rd_addr),
		.rd_data_out(mem_q)
	);

	assign rd_addr = {st.rd_loc, st.rd_beat};
	assign out_edge = single_clock_in ? (k_rise_in || kn_rise_in) : (c_rise_in || cn_rise_in);
	assign rd_data_out = st.q;
	assign rd_data_oe_out = st.oe;

	// ====================================================
	// Port sequencers
	// ====================================================
	always_comb begin
		next_st = st;
		case (st.wr_state)
			SRP_IDLE: begin
				if (k_rise_in && !wr_port_sel_n_in) begin
					next_st.wr_loc = LOC_W'(addr_in);
					next_st.wr_beat = BEAT_FIRST;
					next_st.wr_state = SRP_BURST;
				end
			end
			SRP_BURST: begin
				if (cap_edge) begin
					next_st.wr_beat = st.wr_beat + 2'h1;
					if (st.wr_beat == BEAT_LAST) begin
						next_st.wr_state = SRP_IDLE;
					end
				end
			end
			default: next_st.wr_state = SRP_IDLE;
		endcase
		case (st.rd_state)
			SRP_IDLE: begin
				if (k_rise_in && !rd_port_sel_n_in) begin
					next_st.rd_loc = LOC_W'(addr_in);
					next_st.rd_beat = BEAT_FIRST;
					next_st.rd_state = SRP_BURST;
					next_st.rd_active = 1'b1;
				end
			end
			SRP_BURST: begin
				if (out_edge) begin
					next_st.q = mem_q;
					next_st.oe = 1'b1;
					next_st.rd_beat = st.rd_beat + 2'h1;
					if (st.rd_beat == BEAT_LAST) begin
						next_st.rd_state = SRP_IDLE;
						next_st.rd_active = 1'b0;
					end
				end
			end
			default: next_st.rd_state = SRP_IDLE;
		endcase
		if (st.rd_state == SRP_IDLE && !next_st.rd_active && out_edge) begin
			next_st.oe = 1'b0;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
endmodule

// file: srp_checker.sv
`timescale 1ns/10ps
module srp_checker #(
	parameter int DATA_W = 36
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic k_rise_in,
	input wire logic kn_rise_in,
	input wire logic c_rise_in,
	input wire logic cn_rise_in,
	input wire logic single_clock_in,
	input wire logic rd_port_sel_n_in,
	input wire logic [DATA_W-1:0] rd_data_out,
	input wire logic rd_data_oe_out,
	input wire logic wr_ready_out
);
	logic eo;
	logic st;
	logic [2:0] rem;
	assign eo = single_clock_in ? (k_rise_in | kn_rise_in) : (c_rise_in | cn_rise_in);
	assign st = k_rise_in && !rd_port_sel_n_in && rem == 3'h0;
	// ==========
	// Beats owed by the read burst
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rem <= 3'h0;
		end else if (st) begin
			rem <= 3'h4;
		end else if (eo && rem != 3'h0) begin
			rem <= rem - 3'h1;
		end
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	a_oe_on_beat: assert property (eo && rem != 3'h0 |=> rd_data_oe_out)
		else $error("oe low on beat");
	a_oe_float: assert property (eo && rem == 3'h0 && !st |=> !rd_data_oe_out)
		else $error("oe not dropped");
	a_q_hold: assert property (!eo |=> $stable(rd_data_out) && $stable(rd_data_oe_out))
		else $error("q moved without edge");
	a_oe_rise: assert property ($rose(rd_data_oe_out) |-> $past(eo) && $past(rem) != 3'h0)
		else $error("oe rose outside burst");
	a_start_beat: assert property (st |-> ##[1:20] rd_data_oe_out)
		else $error("read never launched");
	a_no_k_start: assert property (!k_rise_in && rem == 3'h0 && !rd_data_oe_out |=> !rd_data_oe_out)
		else $error("read without k");
	a_ready_high: assert property (wr_ready_out)
		else $error("write blocked");
	a_reset_idle: assert property ($rose(rst_n_in) |-> !rd_data_oe_out && rd_data_out == '0)
		else $error("outputs not idle");
endmodule

// file: srp_ctl_model.sv
`timescale 1ns/10ps
module srp_ctl_model (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic slow_in,
	input wire logic c_en_in,
	output logic k_rise_out,
	output logic kn_rise_out,
	output logic c_rise_out,
	output logic cn_rise_out
);
	logic [2:0] ph;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ph <= 3'h0;
		end else begin
			ph <= ph + (slow_in ? 3'h1 : 3'h2);
		end
	end
	assign k_rise_out = ph == 3'h0;
	assign kn_rise_out = ph == 3'h4;
	assign c_rise_out = c_en_in && ph == 3'h0;
	assign cn_rise_out = c_en_in && ph == 3'h4;
endmodule

// file: testbench.sv
`timescale 1ns/10ps
module testbench;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic slow = 1'b0;
	logic c_en = 1'b1;
	logic k_rise_in, kn_rise_in, c_rise_in, cn_rise_in;
	logic single_clock_in = 1'b0;
	logic wr_port_sel_n_in = 1'b1;
	logic rd_port_sel_n_in = 1'b1;
	logic [18:0] addr_in = '0;
	logic [35:0] wr_data_in = '0;
	logic [3:0] byte_wr_mask_n_in = 4'hf;
	logic [35:0] rd_data_out;
	logic rd_data_oe_out, wr_ready_out;
	logic [35:0] mem [64][4];
	int errors = 0;
	int n_checks = 0;
	always #5 clk_in = ~clk_in;
	srp_ctl_model u_srp_ctl_model (.clk_in, .rst_n_in, .slow_in(slow), .c_en_in(c_en),
		.k_rise_out(k_rise_in), .kn_rise_out(kn_rise_in), .c_rise_out(c_rise_in),
		.cn_rise_out(cn_rise_in));
	srp_sram u_srp_sram (.clk_in, .rst_n_in, .k_rise_in, .kn_rise_in, .c_rise_in,
		.cn_rise_in, .single_clock_in, .wr_port_sel_n_in, .rd_port_sel_n_in, .addr_in,
		.wr_data_in, .byte_wr_mask_n_in, .nibble_wr_mask_n_in(2'h3), .rd_data_out,
		.rd_data_oe_out, .wr_ready_out);
	// ==========
	// Helpers
	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Wait at falling edges for k, k or kn, or an output edge
	task automatic sync(input int s);
		int n;
		n = 0;
		while (n < 40 && !(s == 0 ? k_rise_in : (s == 1 || single_clock_in) ?
			k_rise_in | kn_rise_in : c_rise_in | cn_rise_in)) begin
			@(negedge clk_in);
			n++;
		end
	endtask
	task automatic wr(input logic s, input logic [5:0] a, input logic [35:0] w,
		input logic [15:0] m);
		logic [35:0] kp;
		@(negedge clk_in);
		sync(0);
		wr_port_sel_n_in = s;
		addr_in = {13'h0, a};
		@(negedge clk_in);
		for (int i = 0; i < 4; i++) begin
			sync(1);
			wr_port_sel_n_in = 1'b1;
			addr_in = ~addr_in;
			wr_data_in = w + 36'(i);
			byte_wr_mask_n_in = m[4*i+:4];
			for (int j = 0; j < 4; j++) kp[9*j+:9] = {9{~m[4*i+j]}};
			if (!s) mem[a][i] = (mem[a][i] & ~kp) | (wr_data_in & kp);
			@(negedge clk_in);
		end
	endtask
	task automatic rd(input logic [5:0] a);
		@(negedge clk_in);
		sync(0);
		rd_port_sel_n_in = 1'b0;
		addr_in = {13'h0, a};
		@(negedge clk_in);
		for (int i = 0; i < 4; i++) begin
			sync(2);
			rd_port_sel_n_in = i > 1;
			repeat (2) @(negedge clk_in);
			chk(rd_data_out, mem[a][i]);
			chk({35'h0, rd_data_oe_out}, 36'h1);
		end
	endtask
	// ==========
	// Scenarios
	task automatic t_mask();
		wr(1'b0, 6'h5, 36'h123456789, 16'h0);
		wr(1'b0, 6'h6, 36'h9abcdef01, 16'h0);
		wr(1'b0, 6'h5, 36'hfedcba987, 16'h5a3c);
		rd(6'h5);
		rd(6'h6);
	endtask
	task automatic t_desel();
		wr(1'b1, 6'h5, 36'h0, 16'h0);
		rd(6'h5);
		repeat (12) @(negedge clk_in);
		chk({35'h0, rd_data_oe_out}, 36'h0);
	endtask
	task automatic t_modes();
		single_clock_in = 1'b1;
		c_en = 1'b0;
		rd(6'h6);
		single_clock_in = 1'b0;
		c_en = 1'b1;
		slow = 1'b1;
		wr(1'b0, 6'h7, 36'h0aaaa5555, 16'h0);
		rd(6'h7);
		slow = 1'b0;
	endtask
	task automatic tally_and_finish();
		$display("errors %0d checks %0d", errors, n_checks);
		if (errors == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (16) @(negedge clk_in);
		rst_n_in = 1'b1;
		t_mask();
		t_desel();
		t_modes();
		tally_and_finish();
	end
	initial begin
		#100000;
		errors++;
		tally_and_finish();
	end
endmodule
bind srp_sram srp_checker #(.DATA_W(DATA_W)) u_srp_checker (.clk_in, .rst_n_in, .k_rise_in,
	.kn_rise_in, .c_rise_in, .cn_rise_in, .single_clock_in, .rd_port_sel_n_in, .rd_data_out,
	.rd_data_oe_out, .wr_ready_out);
